// ==== tmr8_pkg.sv ====
package tmr8_pkg;
    localparam logic [3:0] TMR8_OFS_CTRL_A  = 4'h0;
    localparam logic [3:0] TMR8_OFS_CTRL_B  = 4'h1;
    localparam logic [3:0] TMR8_OFS_COUNT   = 4'h2;
    localparam logic [3:0] TMR8_OFS_CMP_A   = 4'h3;
    localparam logic [3:0] TMR8_OFS_CMP_B   = 4'h4;
    localparam logic [3:0] TMR8_OFS_MASK    = 4'h5;
    localparam logic [3:0] TMR8_OFS_FLAG    = 4'h6;
    localparam logic [3:0] TMR8_OFS_SERVICE = 4'h7;
    localparam logic [3:0] TMR8_OFS_PRESC   = 4'h8;
    // Control A: [7:6] action A, [5:4] action B, [1:0] mode low
    localparam int TMR8_CA_ACT_A = 6;
    localparam int TMR8_CA_ACT_B = 4;
    // Control B: [7] force A, [6] force B, [3] mode high, [2:0] clock select
    localparam int TMR8_CB_FORCE_A = 7;
    localparam int TMR8_CB_FORCE_B = 6;
    localparam int TMR8_CB_MODE2   = 3;
    // Flag and mask bit positions
    localparam int TMR8_FB_MATCH_B  = 2;
    localparam int TMR8_FB_MATCH_A  = 1;
    localparam int TMR8_FB_OVERFLOW = 0;
    localparam logic [7:0] TMR8_BOTTOM = 8'h00;
    localparam logic [7:0] TMR8_MAX    = 8'hFF;
    localparam logic [2:0] TMR8_MODE_NORMAL = 3'h0;
    localparam logic [2:0] TMR8_MODE_PC_MAX = 3'h1;
    localparam logic [2:0] TMR8_MODE_CTC    = 3'h2;
    localparam logic [2:0] TMR8_MODE_FP_MAX = 3'h3;
    localparam logic [2:0] TMR8_MODE_PC_OCA = 3'h5;
    localparam logic [2:0] TMR8_MODE_FP_OCA = 3'h7;
    // Clock select codes
    localparam logic [2:0] TMR8_CS_STOP    = 3'h0;
    localparam logic [2:0] TMR8_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] TMR8_CS_EXT_RISE = 3'h7;
    // Prescaler taps whose rising edge gives the divided tick
    localparam int TMR8_TAP_DIV8    = 2;
    localparam int TMR8_TAP_DIV64   = 5;
    localparam int TMR8_TAP_DIV256  = 7;
    localparam int TMR8_TAP_DIV1024 = 9;
    localparam logic [7:0] TMR8_RST_ZERO = 8'h00;
endpackage : tmr8_pkg

// ==== tmr8_core.sv ====
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tmr8_core #(
    parameter int PRESC_W = 10
) (
    // System
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // Avalon-MM slave
    input  wire logic [3:0] avs_address,
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  wire logic [7:0] avs_writedata,
    output logic      [7:0] avs_readdata,
    output logic            avs_waitrequest,
    // Interrupt service acknowledge pulses
    input  wire logic       ack_overflow,
    input  wire logic       ack_match_a,
    input  wire logic       ack_match_b,
    // Pins
    input  wire logic       ext_count_input,
    output logic            wave_out_a,
    output logic            wave_out_b,
    output logic            wave_en_a,
    output logic            wave_en_b,
    // Interrupt requests
    output logic            irq_overflow,
    output logic            irq_match_a,
    output logic            irq_match_b
);
    import tmr8_pkg::*;

    logic [7:0] timer_control_a_r;
    logic [2:0] ctrl_b_r;
    logic       mode_bit2_r;
    logic [7:0] count_value_r;
    logic [7:0] compare_value_a_r;
    logic [7:0] compare_value_b_r;
    logic [7:0] cmp_buf_a_r;
    logic [7:0] cmp_buf_b_r;
    logic [2:0] timer_mask_reg_r;
    logic [2:0] timer_flag_reg_r;
    logic [PRESC_W-1:0] presc_r;
    logic [PRESC_W-1:0] presc_prev_r;
    logic       ext_prev_r;
    logic       dir_down_r;
    logic       block_r;
    logic       wave_a_r;
    logic       wave_b_r;
    logic       ack_r;

    logic [2:0] mode;
    logic [2:0] clock_select_field;
    logic       timer_tick;
    logic       pwm_mode;
    logic       fast_pwm;
    logic       phase_pwm;
    logic [7:0] top_value;
    logic       at_top;
    logic       at_bottom;
    logic       match_a;
    logic       match_b;
    logic       wr;
    logic       wr_count;
    logic       force_a;
    logic       force_b;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;

    assign mode = {mode_bit2_r, timer_control_a_r[1:0]};
    assign clock_select_field = ctrl_b_r;
    // Writes land at the edge that completes the access, never earlier
    assign wr       = avs_write & ack_r;
    assign wr_count = wr && (avs_address == TMR8_OFS_COUNT);
    assign fast_pwm  = (mode == TMR8_MODE_FP_MAX) || (mode == TMR8_MODE_FP_OCA);
    assign phase_pwm = (mode == TMR8_MODE_PC_MAX) || (mode == TMR8_MODE_PC_OCA);
    assign pwm_mode  = fast_pwm | phase_pwm;

    // Top is compare A in modes with bit 2 set and in CTC
    always_comb begin
        if (mode == TMR8_MODE_CTC || mode_bit2_r) begin
            top_value = compare_value_a_r;
        end else begin
            top_value = TMR8_MAX;
        end
    end
    assign at_top    = (count_value_r == top_value);
    assign at_bottom = (count_value_r == TMR8_BOTTOM);
    // Comparators run on every cycle; effect only on ticks
    assign match_a = (count_value_r == compare_value_a_r) & ~block_r;
    assign match_b = (count_value_r == compare_value_b_r) & ~block_r;

    // Prescaler and tick selection
    function automatic logic presc_edge(input logic [PRESC_W-1:0] cur,
                                        input logic [PRESC_W-1:0] prv,
                                        input int bit_i);
        presc_edge = cur[bit_i] & ~prv[bit_i];
    endfunction : presc_edge

    always_comb begin
        case (clock_select_field)
            TMR8_CS_STOP:     timer_tick = 1'b0;
            3'h1:             timer_tick = 1'b1;
            3'h2:             timer_tick = presc_edge(presc_r, presc_prev_r, TMR8_TAP_DIV8);
            3'h3:             timer_tick = presc_edge(presc_r, presc_prev_r, TMR8_TAP_DIV64);
            3'h4:             timer_tick = presc_edge(presc_r, presc_prev_r, TMR8_TAP_DIV256);
            3'h5:             timer_tick = presc_edge(presc_r, presc_prev_r, TMR8_TAP_DIV1024);
            TMR8_CS_EXT_FALL: timer_tick = ext_prev_r & ~ext_count_input;
            default:          timer_tick = ~ext_prev_r & ext_count_input;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            presc_r      <= '0;
            presc_prev_r <= '0;
            ext_prev_r   <= 1'b0;
        end else begin
            presc_r      <= presc_r + 1'b1;
            presc_prev_r <= presc_r;
            ext_prev_r   <= ext_count_input;
        end
    end

    // Bus: one wait cycle per access, answer on the second edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= TMR8_RST_ZERO;
        end else if (avs_read && !ack_r) begin
            if (avs_address == TMR8_OFS_CTRL_A) begin
                avs_readdata <= timer_control_a_r;
            end else if (avs_address == TMR8_OFS_CTRL_B) begin
                avs_readdata <= {4'h0, mode_bit2_r, ctrl_b_r};
            end else if (avs_address == TMR8_OFS_COUNT) begin
                avs_readdata <= count_value_r;
            end else if (avs_address == TMR8_OFS_CMP_A) begin
                avs_readdata <= pwm_mode ? cmp_buf_a_r : compare_value_a_r;
            end else if (avs_address == TMR8_OFS_CMP_B) begin
                avs_readdata <= pwm_mode ? cmp_buf_b_r : compare_value_b_r;
            end else if (avs_address == TMR8_OFS_MASK) begin
                avs_readdata <= {5'h00, timer_mask_reg_r};
            end else if (avs_address == TMR8_OFS_FLAG) begin
                avs_readdata <= {5'h00, timer_flag_reg_r};
            end else begin
                avs_readdata <= TMR8_RST_ZERO;
            end
        end
    end

    // Control registers; action fields act at once
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            timer_control_a_r <= TMR8_RST_ZERO;
            ctrl_b_r          <= 3'h0;
            mode_bit2_r       <= 1'b0;
            timer_mask_reg_r  <= 3'h0;
        end else if (wr) begin
            if (avs_address == TMR8_OFS_CTRL_A) begin
                timer_control_a_r <= avs_writedata;
            end else if (avs_address == TMR8_OFS_CTRL_B) begin
                ctrl_b_r    <= avs_writedata[2:0];
                mode_bit2_r <= avs_writedata[TMR8_CB_MODE2];
            end else if (avs_address == TMR8_OFS_MASK) begin
                timer_mask_reg_r <= avs_writedata[2:0];
            end
        end
    end

    // Force strobes: write-only, ignored in PWM modes
    assign force_a = wr && (avs_address == TMR8_OFS_CTRL_B)
                     && avs_writedata[TMR8_CB_FORCE_A] && !pwm_mode;
    assign force_b = wr && (avs_address == TMR8_OFS_CTRL_B)
                     && avs_writedata[TMR8_CB_FORCE_B] && !pwm_mode;

    // Counter
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count_value_r <= TMR8_RST_ZERO;
            dir_down_r    <= 1'b0;
        end else if (wr_count) begin
            count_value_r <= avs_writedata;
        end else if (timer_tick) begin
            if (phase_pwm) begin
                if (!dir_down_r && at_top) begin
                    dir_down_r    <= 1'b1;
                    count_value_r <= count_value_r - 1'b1;
                end else if (dir_down_r && at_bottom) begin
                    dir_down_r    <= 1'b0;
                    count_value_r <= count_value_r + 1'b1;
                end else begin
                    count_value_r <= dir_down_r ? count_value_r - 1'b1
                                                : count_value_r + 1'b1;
                end
            end else begin
                dir_down_r <= 1'b0;
                if ((mode == TMR8_MODE_CTC || fast_pwm) && at_top) begin
                    count_value_r <= TMR8_BOTTOM;
                end else begin
                    count_value_r <= count_value_r + 1'b1;
                end
            end
        end
    end

    // Count write blocks matches until the next tick has passed
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            block_r <= 1'b0;
        end else if (wr_count) begin
            block_r <= 1'b1;
        end else if (timer_tick) begin
            block_r <= 1'b0;
        end
    end

    // Compare registers with double buffer
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            compare_value_a_r <= TMR8_RST_ZERO;
            compare_value_b_r <= TMR8_RST_ZERO;
            cmp_buf_a_r       <= TMR8_RST_ZERO;
            cmp_buf_b_r       <= TMR8_RST_ZERO;
        end else begin
            if (wr && avs_address == TMR8_OFS_CMP_A) begin
                cmp_buf_a_r <= avs_writedata;
                if (!pwm_mode) begin
                    compare_value_a_r <= avs_writedata;
                end
            end
            if (wr && avs_address == TMR8_OFS_CMP_B) begin
                cmp_buf_b_r <= avs_writedata;
                if (!pwm_mode) begin
                    compare_value_b_r <= avs_writedata;
                end
            end
            // Fast PWM loads at top, phase correct at top while counting up
            if (pwm_mode && timer_tick
                && ((fast_pwm && at_top) || (phase_pwm && at_top && !dir_down_r))) begin
                compare_value_a_r <= cmp_buf_a_r;
                compare_value_b_r <= cmp_buf_b_r;
            end
        end
    end

    // Flags: hardware set wins over clear
    assign flag_set[TMR8_FB_OVERFLOW] = timer_tick &&
        (phase_pwm ? (dir_down_r && at_bottom) : (count_value_r == top_value && mode != TMR8_MODE_CTC)
         || (mode == TMR8_MODE_CTC && count_value_r == TMR8_MAX)) && !wr_count;
    assign flag_set[TMR8_FB_MATCH_A] = timer_tick & match_a;
    assign flag_set[TMR8_FB_MATCH_B] = timer_tick & match_b;
    assign flag_clr[TMR8_FB_OVERFLOW] = ack_overflow |
        (wr && avs_address == TMR8_OFS_FLAG && avs_writedata[TMR8_FB_OVERFLOW]);
    assign flag_clr[TMR8_FB_MATCH_A] = ack_match_a |
        (wr && avs_address == TMR8_OFS_FLAG && avs_writedata[TMR8_FB_MATCH_A]);
    assign flag_clr[TMR8_FB_MATCH_B] = ack_match_b |
        (wr && avs_address == TMR8_OFS_FLAG && avs_writedata[TMR8_FB_MATCH_B]);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            timer_flag_reg_r <= 3'h0;
        end else begin
            timer_flag_reg_r <= flag_set | (timer_flag_reg_r & ~flag_clr);
        end
    end
    assign irq_overflow = timer_flag_reg_r[TMR8_FB_OVERFLOW] & timer_mask_reg_r[TMR8_FB_OVERFLOW];
    assign irq_match_a  = timer_flag_reg_r[TMR8_FB_MATCH_A] & timer_mask_reg_r[TMR8_FB_MATCH_A];
    assign irq_match_b  = timer_flag_reg_r[TMR8_FB_MATCH_B] & timer_mask_reg_r[TMR8_FB_MATCH_B];

    // Waveform generator for one channel
    function automatic logic wave_next(input logic cur, input logic [1:0] act,
                                       input logic hit, input logic frc,
                                       input logic bot, input logic down);
        wave_next = cur;
        if (fast_pwm || phase_pwm) begin
            if (act[1]) begin
                if (hit) begin
                    wave_next = phase_pwm ? (act[0] ^ down) : act[0];
                end else if (fast_pwm && bot) begin
                    wave_next = ~act[0];
                end
            end
        end else if (hit || frc) begin
            case (act)
                2'h1:    wave_next = ~cur;
                2'h2:    wave_next = 1'b0;
                2'h3:    wave_next = 1'b1;
                default: wave_next = cur;
            endcase
        end
    endfunction : wave_next

    // Output state survives mode changes; only reset and the match, bottom or force actions change it
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wave_a_r <= 1'b0;
            wave_b_r <= 1'b0;
        end else begin
            wave_a_r <= wave_next(wave_a_r, timer_control_a_r[TMR8_CA_ACT_A +: 2],
                                  timer_tick & match_a, force_a,
                                  timer_tick & at_bottom, dir_down_r);
            wave_b_r <= wave_next(wave_b_r, timer_control_a_r[TMR8_CA_ACT_B +: 2],
                                  timer_tick & match_b, force_b,
                                  timer_tick & at_bottom, dir_down_r);
        end
    end
    assign wave_out_a = wave_a_r;
    assign wave_out_b = wave_b_r;
    assign wave_en_a  = |timer_control_a_r[TMR8_CA_ACT_A +: 2];
    assign wave_en_b  = |timer_control_a_r[TMR8_CA_ACT_B +: 2];
endmodule : tmr8_core
`default_nettype wire

// ==== tmr8_core_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmr8_core_asserts
    import tmr8_pkg::*;
#(
    parameter int PRESC_W = 10
) (
    // System
    input wire logic       sys_clk,
    input wire logic       nrst,
    // Bus
    input wire logic [3:0] avs_address,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic [7:0] avs_readdata,
    input wire logic       avs_waitrequest,
    // Service and pins
    input wire logic       ack_overflow,
    input wire logic       ack_match_a,
    input wire logic       wave_out_a,
    input wire logic       wave_out_b,
    input wire logic       wave_en_a,
    input wire logic       wave_en_b,
    input wire logic       irq_overflow,
    input wire logic       irq_match_a
);
    logic ctla_wr_r;
    logic flag_wr;
    // Mask, flag and service writes may legally drop a request
    assign flag_wr = avs_write && !avs_waitrequest && avs_address >= TMR8_OFS_MASK
                     && avs_address <= TMR8_OFS_SERVICE;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctla_wr_r <= 1'h0;
        end else begin
            ctla_wr_r <= avs_write && !avs_waitrequest && avs_address == TMR8_OFS_CTRL_A;
        end
    end
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence access_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence answer_s;
        !avs_waitrequest;
    endsequence
    wait_answer_a: assert property (access_s |=> answer_s)
        else $error("bus access not answered in one cycle");
    enable_a_a: assert property ($changed(wave_en_a) |-> ctla_wr_r)
        else $error("pin enable A moved without a control write");
    enable_b_a: assert property ($changed(wave_en_b) |-> ctla_wr_r)
        else $error("pin enable B moved without a control write");
    reset_clear_a: assert property ($rose(nrst) |-> !wave_out_a && !wave_out_b)
        else $error("output state not cleared by reset");
    ovf_hold_a: assert property (irq_overflow && !ack_overflow && !flag_wr |=> irq_overflow)
        else $error("overflow request dropped uncleared");
    ovf_ack_a: assert property (ack_overflow |=> !irq_overflow)
        else $error("overflow request kept after service");
    match_ack_a: assert property (ack_match_a |=> !irq_match_a)
        else $error("match A request kept after service");
    rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
endmodule : tmr8_core_asserts
bind tmr8_core tmr8_core_asserts #(.PRESC_W(PRESC_W)) u_tmr8_core_asserts (
    .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ack_overflow(ack_overflow), .ack_match_a(ack_match_a), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .wave_en_a(wave_en_a), .wave_en_b(wave_en_b),
    .irq_overflow(irq_overflow), .irq_match_a(irq_match_a));
`default_nettype wire

// ==== tmr8_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmr8_far_model (
    // System
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // Interrupt service
    input  wire logic       svc_en,
    input  wire logic       irq_overflow,
    input  wire logic       irq_match_a,
    input  wire logic       irq_match_b,
    output logic            ack_overflow,
    output logic            ack_match_a,
    output logic            ack_match_b,
    output logic      [7:0] n_ack,
    // Count pin
    input  wire logic       ext_run,
    output logic            ext_count_input
);
    logic [2:0] pend;
    logic [2:0] ack;
    logic [1:0] ph;
    assign {ack_overflow, ack_match_a, ack_match_b} = ack;
    // One pulse per request, at most every third cycle; repeats while the request stays high
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pend  <= 3'h0;
            ack   <= 3'h0;
            n_ack <= 8'h00;
        end else begin
            pend  <= {3{svc_en}} & {irq_overflow, irq_match_a, irq_match_b} & ~pend & ~ack;
            ack   <= pend;
            n_ack <= n_ack + {7'h00, ack[1]};
        end
    end
    // Pin idles low between bursts
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ph              <= 2'h0;
            ext_count_input <= 1'h0;
        end else if (ext_run) begin
            ph <= ph + 2'h1;
            if (ph[0]) begin
                ext_count_input <= ~ext_count_input;
            end
        end else begin
            ext_count_input <= 1'h0;
        end
    end
endmodule : tmr8_far_model
`default_nettype wire

// ==== tmr8_core_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmr8_core_bench;
    import tmr8_pkg::*;
    logic       sys_clk, nrst, avs_read, avs_write, avs_waitrequest, svc_en, ext_run, ext_in;
    logic       ack_ov, ack_a, ack_b, out_a, out_b, en_a, en_b, irq_ov, irq_a, irq_b;
    logic [3:0] avs_address;
    logic [7:0] avs_writedata, avs_readdata, n_ack, rd, c0, mx;
    int         errors, total_checks, cyc, rises, n;

    tmr8_core u_tmr8_core (.sys_clk(sys_clk), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ack_overflow(ack_ov), .ack_match_a(ack_a),
        .ack_match_b(ack_b), .ext_count_input(ext_in), .wave_out_a(out_a), .wave_out_b(out_b),
        .wave_en_a(en_a), .wave_en_b(en_b), .irq_overflow(irq_ov), .irq_match_a(irq_a),
        .irq_match_b(irq_b));
    tmr8_far_model u_tmr8_far_model (.sys_clk(sys_clk), .nrst(nrst), .svc_en(svc_en),
        .irq_overflow(irq_ov), .irq_match_a(irq_a), .irq_match_b(irq_b),
        .ack_overflow(ack_ov), .ack_match_a(ack_a), .ack_match_b(ack_b), .n_ack(n_ack),
        .ext_run(ext_run), .ext_count_input(ext_in));

    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            results();
        end
    end
    always @(posedge ext_in) rises++;

    task results;
        if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask : chk
    // Holds the request until waitrequest is sampled low
    task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 50);
        rd = avs_readdata;
        if (n == 50) errors++;
        avs_write <= 1'h0;
        avs_read  <= 1'h0;
        @(posedge sys_clk);
    endtask : acc
    task rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
        acc(1'h0, a, 8'h00);
        chk(nm, e, rd);
    endtask : rchk

    initial begin
        {nrst, avs_read, avs_write, svc_en, ext_run} = 5'h00;
        {avs_address, avs_writedata} = 12'h000;
        errors = 0;
        total_checks = 0;
        cyc = 0;
        rises = 0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'h1;
        @(posedge sys_clk);
        chk("out_a", 8'h00, {7'h00, out_a});
        rchk("ctrl_a", TMR8_OFS_CTRL_A, 8'h00);
        rchk("flags", TMR8_OFS_FLAG, 8'h00);
        rchk("unmapped", 4'hF, 8'h00);
        acc(1'h1, TMR8_OFS_CMP_A, 8'h5A);
        rchk("cmp_a", TMR8_OFS_CMP_A, 8'h5A);
        acc(1'h1, TMR8_OFS_COUNT, 8'h10);
        repeat (10) @(posedge sys_clk);
        rchk("frozen", TMR8_OFS_COUNT, 8'h10);
        acc(1'h1, TMR8_OFS_CTRL_A, 8'h50);
        chk("en_ab", 8'h03, {6'h00, en_a, en_b});
        acc(1'h1, TMR8_OFS_CTRL_B, 8'h80);
        chk("forced_a", 8'h01, {7'h00, out_a});
        acc(1'h1, TMR8_OFS_CTRL_B, 8'h40);
        chk("forced_b", 8'h01, {7'h00, out_b});
        rchk("ctrl_b", TMR8_OFS_CTRL_B, 8'h00);
        rchk("no_flag", TMR8_OFS_FLAG, 8'h00);
        rchk("no_reload", TMR8_OFS_COUNT, 8'h10);
        // Fast PWM refuses the force; state must survive the switch
        acc(1'h1, TMR8_OFS_CTRL_A, 8'h53);
        acc(1'h1, TMR8_OFS_CTRL_B, 8'h80);
        chk("kept_a", 8'h01, {7'h00, out_a});
        acc(1'h1, TMR8_OFS_CTRL_A, 8'h50);
        acc(1'h1, TMR8_OFS_CMP_B, 8'h20);
        acc(1'h1, TMR8_OFS_COUNT, 8'h20);
        acc(1'h1, TMR8_OFS_CTRL_B, 8'h01);
        acc(1'h1, TMR8_OFS_CTRL_B, 8'h00);
        rchk("blocked", TMR8_OFS_FLAG, 8'h00);
        acc(1'h1, TMR8_OFS_COUNT, 8'hFA);
        acc(1'h1, TMR8_OFS_MASK, 8'h01);
        acc(1'h1, TMR8_OFS_CTRL_B, 8'h01);
        for (int i = 0; i < 100 && irq_ov !== 1'h1; i++) @(posedge sys_clk);
        chk("ovf_irq", 8'h01, {7'h00, irq_ov});
        acc(1'h1, TMR8_OFS_CTRL_B, 8'h00);
        acc(1'h0, TMR8_OFS_FLAG, 8'h00);
        chk("ovf_flag", 8'h01, {7'h00, rd[0]});
        acc(1'h1, TMR8_OFS_FLAG, 8'h01);
        chk("ovf_clr", 8'h00, {7'h00, irq_ov});
        // Second wrap, cleared by the serviced interrupt this time
        svc_en <= 1'h1;
        acc(1'h1, TMR8_OFS_COUNT, 8'hFA);
        acc(1'h1, TMR8_OFS_CTRL_B, 8'h01);
        repeat (12) @(posedge sys_clk);
        acc(1'h1, TMR8_OFS_CTRL_B, 8'h00);
        svc_en <= 1'h0;
        rchk("ovf_svc", TMR8_OFS_FLAG, 8'h00);
        acc(1'h1, TMR8_OFS_MASK, 8'h04);
        acc(1'h1, TMR8_OFS_COUNT, 8'h1F);
        acc(1'h1, TMR8_OFS_CTRL_B, 8'h01);
        for (int i = 0; i < 100 && irq_b !== 1'h1; i++) @(posedge sys_clk);
        chk("irq_b", 8'h01, {7'h00, irq_b});
        acc(1'h1, TMR8_OFS_CTRL_B, 8'h00);
        chk("match_b_out", 8'h00, {7'h00, out_b});
        acc(1'h1, TMR8_OFS_FLAG, 8'h04);
        chk("b_clr", 8'h00, {7'h00, irq_b});
        acc(1'h1, TMR8_OFS_MASK, 8'h02);
        acc(1'h1, TMR8_OFS_CMP_A, 8'h05);
        acc(1'h1, TMR8_OFS_COUNT, 8'h00);
        acc(1'h1, TMR8_OFS_CTRL_A, 8'h42);
        svc_en <= 1'h1;
        acc(1'h1, TMR8_OFS_CTRL_B, 8'h01);
        mx = 8'h00;
        repeat (20) begin
            acc(1'h0, TMR8_OFS_COUNT, 8'h00);
            if (rd > mx) mx = rd;
        end
        chk("ctc_top", 8'h01, {7'h00, mx <= 8'h05});
        chk("serviced", 8'h01, {7'h00, n_ack >= 8'h02});
        svc_en <= 1'h0;
        acc(1'h1, TMR8_OFS_MASK, 8'h00);
        acc(1'h1, TMR8_OFS_CTRL_A, 8'h00);
        acc(1'h1, TMR8_OFS_CTRL_B, 8'h07);
        acc(1'h0, TMR8_OFS_COUNT, 8'h00);
        c0 = rd;
        rises = 0;
        ext_run <= 1'h1;
        repeat (24) @(posedge sys_clk);
        ext_run <= 1'h0;
        repeat (8) @(posedge sys_clk);
        rchk("ext_ticks", TMR8_OFS_COUNT, c0 + 8'(rises));
        // Divide by 8 over 83 clock edges gives 10 or 11 ticks
        acc(1'h1, TMR8_OFS_COUNT, 8'h00);
        acc(1'h1, TMR8_OFS_CTRL_B, 8'h02);
        repeat (80) @(posedge sys_clk);
        acc(1'h1, TMR8_OFS_CTRL_B, 8'h00);
        acc(1'h0, TMR8_OFS_COUNT, 8'h00);
        chk("presc_div8", 8'h01, {7'h00, rd >= 8'h0A && rd <= 8'h0B});
        results();
    end
endmodule : tmr8_core_bench
`default_nettype wire
